/* inc/pced_defs.svh */
// Purpose: address map, field positions and reset values of the pin change detector
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef PCED_DEFS_SVH
`define PCED_DEFS_SVH

`define PCED_AW          8
`define PCED_OFF_B_RISE  8'h00
`define PCED_OFF_B_FALL  8'h04
`define PCED_OFF_B_FLAG  8'h08
`define PCED_OFF_C_RISE  8'h0c
`define PCED_OFF_C_FALL  8'h10
`define PCED_OFF_C_FLAG  8'h14
`define PCED_OFF_E_RISE  8'h18
`define PCED_OFF_E_FALL  8'h1c
`define PCED_OFF_E_FLAG  8'h20
`define PCED_OFF_CTRL    8'h24
`define PCED_OFF_IRQ_ST  8'h28
`define PCED_OFF_IRQ_MSK 8'h2c
`define PCED_OFF_SUMMARY 8'h30

`define PCED_B_LSB       0
`define PCED_C_LSB       8
`define PCED_E_IDX       16
`define PCED_E_BIT       3
`define PCED_CTRL_MASTER 0
`define PCED_EVT_B       0
`define PCED_EVT_C       1
`define PCED_EVT_E       2
`define PCED_SUM_BIT     0

`define PCED_RST_PINS    17'h00000
`define PCED_RST_EVT     3'h0
`define PCED_RST_WORD    32'h0000_0000

`endif

/* inc/pced_pkg.sv */
// Purpose: types shared by the pin change detector
// Assumes: ports b and c are eight pins wide, port e has one pin
// Notes:   pins travel packed, port b in the low byte
package pced_pkg;

	typedef struct packed {
		logic       e3;
		logic [7:0] c;
		logic [7:0] b;
	} pced_pins_t;

	typedef logic [16:0] pced_pvec_t;

	typedef enum logic [1:0] {
		PCED_IDLE = 2'b00,
		PCED_ACC  = 2'b01
	} pced_phase_t;

	typedef struct packed {
		pced_phase_t phase;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		pced_pvec_t  sync1;
		pced_pvec_t  sync2;
		pced_pvec_t  sync3;
		pced_pvec_t  filt;
		pced_pvec_t  rise_en;
		pced_pvec_t  fall_en;
		pced_pvec_t  flags;
		logic        master_en;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic        irq;
		logic        summary;
	} pced_state_t;

endpackage

/* logic/pced_top.sv */
// Purpose: pin change edge detector for ports b, c and pin 3 of port e, APB slave
// Assumes: pins are asynchronous to pclk; zero-wait APB answers
`include "pced_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pced_top #(
	parameter int PORT_W = 8
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`PCED_AW-1:0]  paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire pced_pkg::pced_pins_t pin_in,
	output logic                      summary_change_flag,
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////////
	// the packed pin layout fixes the port width
	generate
		if (PORT_W != 8) begin : g_bad_width
			$error("pced_top: PORT_W must be 8");
		end
	endgenerate

	pced_pkg::pced_state_t s;
	pced_pkg::pced_state_t n;
	pced_pkg::pced_pvec_t  pin_v;
	pced_pkg::pced_pvec_t  agree;
	pced_pkg::pced_pvec_t  rise;
	pced_pkg::pced_pvec_t  fall;
	pced_pkg::pced_pvec_t  hit;
	pced_pkg::pced_pvec_t  flag_wr;
	logic [7:0]            rd;
	logic                  rd_err;
	logic                  wr;
	logic                  wr_flag;
	logic [2:0]            evt;
	logic [2:0]            w1c;

	assign pin_v = pin_in;

	////////////////////////////////////////////////////////////////////////////
	// read decode, unimplemented port e bits stay zero
	always_comb begin
		rd     = 8'h00;
		rd_err = 1'b0;
		case (paddr)
			`PCED_OFF_B_RISE: begin
				rd = s.rise_en[`PCED_B_LSB +: 8];
			end
			`PCED_OFF_B_FALL: begin
				rd = s.fall_en[`PCED_B_LSB +: 8];
			end
			`PCED_OFF_B_FLAG: begin
				rd = s.flags[`PCED_B_LSB +: 8];
			end
			`PCED_OFF_C_RISE: begin
				rd = s.rise_en[`PCED_C_LSB +: 8];
			end
			`PCED_OFF_C_FALL: begin
				rd = s.fall_en[`PCED_C_LSB +: 8];
			end
			`PCED_OFF_C_FLAG: begin
				rd = s.flags[`PCED_C_LSB +: 8];
			end
			`PCED_OFF_E_RISE: begin
				rd[`PCED_E_BIT] = s.rise_en[`PCED_E_IDX];
			end
			`PCED_OFF_E_FALL: begin
				rd[`PCED_E_BIT] = s.fall_en[`PCED_E_IDX];
			end
			`PCED_OFF_E_FLAG: begin
				rd[`PCED_E_BIT] = s.flags[`PCED_E_IDX];
			end
			`PCED_OFF_CTRL: begin
				rd[`PCED_CTRL_MASTER] = s.master_en;
			end
			`PCED_OFF_IRQ_ST: begin
				rd[2:0] = s.irq_status;
			end
			`PCED_OFF_IRQ_MSK: begin
				rd[2:0] = s.irq_mask;
			end
			`PCED_OFF_SUMMARY: begin
				rd[`PCED_SUM_BIT] = s.summary;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		n = s;
		// three stages; first stage feeds only the second
		n.sync1 = pin_v;
		n.sync2 = s.sync1;
		n.sync3 = s.sync2;
		// a change counts once stages two and three agree
		agree  = ~(s.sync2 ^ s.sync3);
		n.filt = (agree & s.sync3) | (~agree & s.filt);
		// compare against last accepted level, one-cycle pulse
		rise = agree & s.sync3 & ~s.filt & s.rise_en;
		fall = agree & ~s.sync3 & s.filt & s.fall_en;
		hit  = rise | fall;

		// write takes effect at the access edge only
		wr      = (s.phase == pced_pkg::PCED_ACC) & psel & penable & pwrite & ~s.pslverr;
		wr_flag = 1'b0;
		flag_wr = s.flags;
		w1c     = `PCED_RST_EVT;
		if (wr) begin
			case (paddr)
				`PCED_OFF_B_RISE: begin
					n.rise_en[`PCED_B_LSB +: 8] = pwdata[7:0];
				end
				`PCED_OFF_B_FALL: begin
					n.fall_en[`PCED_B_LSB +: 8] = pwdata[7:0];
				end
				`PCED_OFF_B_FLAG: begin
					flag_wr[`PCED_B_LSB +: 8] = pwdata[7:0];
					wr_flag = 1'b1;
				end
				`PCED_OFF_C_RISE: begin
					n.rise_en[`PCED_C_LSB +: 8] = pwdata[7:0];
				end
				`PCED_OFF_C_FALL: begin
					n.fall_en[`PCED_C_LSB +: 8] = pwdata[7:0];
				end
				`PCED_OFF_C_FLAG: begin
					flag_wr[`PCED_C_LSB +: 8] = pwdata[7:0];
					wr_flag = 1'b1;
				end
				`PCED_OFF_E_RISE: begin
					n.rise_en[`PCED_E_IDX] = pwdata[`PCED_E_BIT];
				end
				`PCED_OFF_E_FALL: begin
					n.fall_en[`PCED_E_IDX] = pwdata[`PCED_E_BIT];
				end
				`PCED_OFF_E_FLAG: begin
					flag_wr[`PCED_E_IDX] = pwdata[`PCED_E_BIT];
					wr_flag = 1'b1;
				end
				`PCED_OFF_CTRL: begin
					n.master_en = pwdata[`PCED_CTRL_MASTER];
				end
				`PCED_OFF_IRQ_ST: begin
					w1c = pwdata[2:0];
				end
				`PCED_OFF_IRQ_MSK: begin
					n.irq_mask = pwdata[2:0];
				end
				default: begin
					w1c = `PCED_RST_EVT;
				end
			endcase
		end
		// hardware set wins over any software write
		n.flags   = flag_wr | hit;
		n.summary = |n.flags;

		evt[`PCED_EVT_B] = |hit[`PCED_B_LSB +: 8];
		evt[`PCED_EVT_C] = |hit[`PCED_C_LSB +: 8];
		evt[`PCED_EVT_E] = hit[`PCED_E_IDX];
		n.irq_status     = (s.irq_status & ~w1c) | evt;
		// detection runs regardless; only the request is gated
		n.irq = n.master_en & |(n.irq_status & n.irq_mask);

		// apb phases; read data taken at the setup edge
		case (s.phase)
			pced_pkg::PCED_IDLE: begin
				if (psel & ~penable) begin
					n.phase   = pced_pkg::PCED_ACC;
					n.pready  = 1'b1;
					n.pslverr = rd_err;
					n.prdata  = {24'h00_0000, rd};
				end
			end
			pced_pkg::PCED_ACC: begin
				n.phase   = pced_pkg::PCED_IDLE;
				n.pready  = 1'b0;
				n.pslverr = 1'b0;
				n.prdata  = `PCED_RST_WORD;
			end
			default: begin
				n.phase  = pced_pkg::PCED_IDLE;
				n.pready = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// all state clears on any reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign prdata              = s.prdata;
	assign pready              = s.pready;
	assign pslverr             = s.pslverr;
	assign summary_change_flag = s.summary;
	assign irq                 = s.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_rise_sets_flag: assert property (
		(rise != '0) |=> ((s.flags & $past(rise)) == $past(rise))
	) else $error("enabled rising edge did not set its flag");

	chk_fall_sets_flag: assert property (
		(fall != '0) |=> ((s.flags & $past(fall)) == $past(fall))
	) else $error("enabled falling edge did not set its flag");

	chk_flag_needs_cause: assert property (
		(!wr_flag && hit == '0) |=> ((s.flags & ~$past(s.flags)) == '0)
	) else $error("flag set without enabled edge or write");

	chk_set_beats_clear: assert property (
		(wr_flag && hit != '0) |=> ((s.flags & $past(hit)) == $past(hit))
	) else $error("edge lost during clearing write");

	chk_zero_write_clears: assert property (
		(wr && paddr == `PCED_OFF_B_FLAG && pwdata[7:0] == 8'h00
			&& hit[`PCED_B_LSB +: 8] == 8'h00)
		|=> (s.flags[`PCED_B_LSB +: 8] == 8'h00)
	) else $error("writing zero did not clear port b flags");

	chk_summary_or: assert property (
		##1 (summary_change_flag == (s.flags != '0))
	) else $error("summary flag differs from or of flags");

	chk_summary_on_edge: assert property (
		(hit != '0) |=> summary_change_flag
	) else $error("summary flag not set by enabled edge");

	chk_irq_gated: assert property (
		!$past(s.master_en) ##0 !s.master_en |-> !irq
	) else $error("interrupt raised with master enable clear");

	chk_e_spare_zero: assert property (
		(s.phase == pced_pkg::PCED_IDLE && psel && !penable
			&& (paddr == `PCED_OFF_E_RISE || paddr == `PCED_OFF_E_FALL))
		|=> ((prdata[7:0] & 8'hf7) == 8'h00)
	) else $error("unimplemented port e enable bits read nonzero");

	chk_edge_one_pulse: assert property (
		(hit != '0) |=> ((hit & $past(hit)) == '0)
	) else $error("edge pulse lasted more than one cycle");

	chk_pin_latency: assert property (
		(s.rise_en[`PCED_C_LSB] && !s.filt[`PCED_C_LSB] && !s.sync3[`PCED_C_LSB]
			&& s.sync2[`PCED_C_LSB] && s.sync1[`PCED_C_LSB])
		|=> ##1 (s.flags[`PCED_C_LSB] || !s.rise_en[`PCED_C_LSB])
	) else $error("stable rising pin not flagged two cycles later");

	chk_pready_pulse: assert property (
		pready |=> !pready
	) else $error("pready held longer than one cycle");

	cov_rise_e: cover property (
		rise[`PCED_E_IDX]
	);

	cov_clear_race: cover property (
		wr_flag && hit != '0
	);

	cov_irq: cover property (
		$rose(irq)
	);

	cov_both_edges: cover property (
		rise[`PCED_B_LSB] ##[1:20] fall[`PCED_B_LSB]
	);

endmodule

`default_nettype wire

/* dv/pced_pin_model.sv */
// Purpose: external pin driver standing in front of the change detector
// Assumes: pins are plain logic levels that the board always drives
// Notes:   levels change just after a pclk rising edge
`timescale 1ns/1ps
`default_nettype none

module pced_pin_model (
	input  wire logic                 pclk,
	input  wire pced_pkg::pced_pins_t want,
	output var  pced_pkg::pced_pins_t pin_in
);
	// pins are held steady for many cycles so no short pulse is lost
	always @(posedge pclk) begin
		pin_in <= want;
	end
endmodule

`default_nettype wire

/* dv/tb_top.sv */
// Purpose: self-checking bench of the pin change detector
// Assumes: zero-wait apb slave, flag visible a few edges after a pin moves
// Notes:   pins settle before each check by a fixed wait
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [7:0]           paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic                 summary_change_flag;
	logic                 irq;
	pced_pkg::pced_pins_t want;
	pced_pkg::pced_pins_t pin_in;
	int                   n_mismatch;
	int                   compares;
	int                   cyc;

	pced_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.summary_change_flag(summary_change_flag), .irq(irq));
	pced_pin_model pins_far (.pclk(pclk), .want(want), .pin_in(pin_in));

	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// pready is read before the edge's own updates land
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask

	// three sync stages plus the model's own flop
	task automatic settle;
		repeat (6) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		for (int a = 0; a <= 8'h30; a += 4) begin
			rd(8'(a), 32'h0);
		end
		chk({30'h0, irq, summary_change_flag}, 32'h0);
		apb(1'b0, 8'h34, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
	endtask

	task automatic t_port_b;
		wr(8'h00, 32'h01);
		wr(8'h04, 32'h02);
		want.b <= 8'h03;
		settle();
		rd(8'h08, 32'h01);
		chk({31'h0, summary_change_flag}, 32'h1);
		want.b <= 8'h00;
		settle();
		rd(8'h08, 32'h03);
	endtask

	task automatic t_port_c;
		wr(8'h0c, 32'h80);
		wr(8'h10, 32'h40);
		want.c <= 8'hc0;
		settle();
		rd(8'h14, 32'h80);
		want.c <= 8'h00;
		settle();
		rd(8'h14, 32'hc0);
	endtask

	task automatic t_port_e;
		wr(8'h18, 32'hff);
		rd(8'h18, 32'h08);
		wr(8'h1c, 32'hff);
		rd(8'h1c, 32'h08);
		want.e3 <= 1'b1;
		settle();
		rd(8'h20, 32'h08);
		wr(8'h20, 32'h00);
		want.e3 <= 1'b0;
		settle();
		rd(8'h20, 32'h08);
	endtask

	// read-modify-write: drop only the bit already known to have changed
	task automatic t_clear;
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h08, 32'h0, r, e);
		chk(r, 32'h03);
		wr(8'h08, r & ~32'h02);
		rd(8'h08, 32'h01);
		wr(8'h08, 32'h00);
		wr(8'h14, 32'h00);
		wr(8'h20, 32'h00);
		rd(8'h30, 32'h00);
		chk({31'h0, summary_change_flag}, 32'h0);
		wr(8'h14, 32'h01);
		rd(8'h14, 32'h01);
		rd(8'h30, 32'h01);
		wr(8'h14, 32'h00);
	endtask

	// pin edge reaches the flag on the very edge of a clearing write
	task automatic t_race;
		want.c <= 8'h80;
		repeat (3) @(posedge pclk);
		wr(8'h14, 32'h00);
		rd(8'h14, 32'h80);
		want.c <= 8'h00;
		settle();
		wr(8'h14, 32'h00);
		rd(8'h30, 32'h00);
	endtask

	// second reset with some edge enables set and mask and master enable all set
	task automatic t_rereset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
	endtask

	task automatic t_irq;
		rd(8'h28, 32'h07);
		wr(8'h2c, 32'h07);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		wr(8'h24, 32'h01);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(8'h28, 32'h07);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rd(8'h28, 32'h00);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// generous ceiling, the full run needs well under a tenth of it
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		want = '0;
		n_mismatch = 0;
		compares = 0;
		cyc = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_port_b();
		t_port_c();
		t_port_e();
		t_clear();
		t_race();
		t_irq();
		t_rereset();
		give_verdict();
	end
endmodule

`default_nettype wire
